/* File: rtl/wdog_consts.vh */
// Timing constants for the pin-selectable watchdog.
// Assumes a 100 MHz system clock and a 1 us prescaler tick.
`ifndef WDOG_CONSTS_VH
`define WDOG_CONSTS_VH

// System clock period in ns and prescaler tick in ns
`define CLK_PERIOD_NS 10
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)

// Select code that disables the watchdog
`define SEL_DISABLED 3'b011

// Settle interval, in us ticks (at most 300 us)
`define SETTLE_US 300

// Fault pulse widths in us: open-drain class and push-pull class
`define PULSE_OD_US 150000
`define PULSE_PP_US 1500

// Time-table values in us
`define T_30US 30
`define T_200US 200
`define T_1MS 1000
`define T_3MS 3000
`define T_10MS 10000
`define T_30MS 30000
`define T_100MS 100000
`define T_300MS 300000
`define T_1S 1000000
`define T_3S 3000000
`define T_10S 10000000
`define T_60S 60000000

// Variant codes
`define VAR_EQUAL 2'd0
`define VAR_LONG 2'd1
`define VAR_SPLIT 2'd2

`endif

/* File: rtl/sync2.v */
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes the inputs are quasi-static relative to clk_sys.
`default_nettype none

module sync2 #(
  parameter WIDTH = 1
) (
  // Clock
  input wire clk_sys,
  // Data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  // First flop feeds only the second
  always @(posedge clk_sys) begin
    meta_reg <= async_in;
    stable_reg <= meta_reg;
  end

  assign sync_out = stable_reg;

endmodule // sync2

`default_nettype wire

/* File: rtl/pin_selectable_watchdog.v */
// Pin-selectable watchdog supervisor with three timing variants.
// Assumes kick and select pins are asynchronous; reset acts as power-up.
// Operation
// - Either kick edge restarts the timeout count
// - Asserting fault clears the timeout count
// - Kick idle a full timeout pulses fault low
// - Pulse width 100-300 ms or 1-3 ms
// - Ignore kick during settle after power-up/select change
// - Select 011 disables counting and pulses
// - Variant one: startup delay equals timeout table
// - Variant two: 60 s startup, own timeout table
// - Variant three: separate delay and timeout tables
// - First-edge settings wait for first kick edge
// - Startup delay blocks counting and fault pulses
// - Settle interval lasts at most 300 us
// - Select change waits for running pulse end
// - Fresh timeout after pulse; ignore kicks meanwhile
`default_nettype none
`include "wdog_consts.vh"

module pin_selectable_watchdog #(
  parameter VARIANT = 0,         // 0 equal, 1 long, 2 split
  parameter PUSH_PULL = 0,       // 0 open-drain class, 1 push-pull class
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Processor side pins
  input wire kick_in,
  input wire timing_sel_bit0,
  input wire timing_sel_bit1,
  input wire timing_sel_bit2,
  // Fault output, open-drain style pair
  output reg fault_pulse_n,
  output reg fault_oe,
  // Status
  output reg disabled_out
);

  localparam ST_SETTLE = 5'h01;
  localparam ST_STARTUP = 5'h02;
  localparam ST_RUN = 5'h04;
  localparam ST_FAULT = 5'h08;
  localparam ST_OFF = 5'h10;
  localparam [31:0] PULSE_US = PUSH_PULL ? `PULSE_PP_US : `PULSE_OD_US;
  localparam [31:0] FIRST_EDGE = 32'hffffffff;

  wire [3:0] pins_sync;
  wire kick_s;
  wire [2:0] sel_s;
  reg kick_prev_reg;
  reg [2:0] sel_prev_reg;
  reg [4:0] state_reg;
  reg [31:0] tick_div_reg;
  reg [31:0] count_reg;
  reg [2:0] sel_live_reg;
  reg change_pend_reg;
  reg [31:0] t_delay;
  reg [31:0] t_wd;
  wire tick;
  wire kick_edge;
  wire sel_changed;

  // Synchronise pins before use
  sync2 #(.WIDTH(4)) u_sync (
    .clk_sys(clk_sys),
    .async_in({timing_sel_bit2, timing_sel_bit1, timing_sel_bit0, kick_in}),
    .sync_out(pins_sync)
  );
  assign kick_s = pins_sync[0];
  assign sel_s = pins_sync[3:1];
  assign kick_edge = kick_s ^ kick_prev_reg;
  assign sel_changed = sel_s != sel_prev_reg;

  // Microsecond prescaler
  always @(posedge clk_sys) begin
    if (reset || tick_div_reg == TICK_CYCLES - 1) begin
      tick_div_reg <= 32'h0;
    end else begin
      tick_div_reg <= tick_div_reg + 32'h1;
    end
  end
  assign tick = tick_div_reg == TICK_CYCLES - 1;

  // Timing tables; values are minimums, counts run to 1.5x
  always @* begin
    t_wd = `T_1MS;
    t_delay = `T_1MS;
    case (VARIANT)
      0: begin
        case (sel_live_reg)
          3'b000: t_wd = `T_1MS;
          3'b001: t_wd = `T_10MS;
          3'b010: t_wd = `T_30MS;
          3'b100: t_wd = `T_100MS;
          3'b101: t_wd = `T_1S;
          3'b110: t_wd = `T_10S;
          default: t_wd = `T_60S;
        endcase
        t_delay = t_wd;
      end
      1: begin
        case (sel_live_reg)
          3'b000: t_wd = `T_1MS;
          3'b001: t_wd = `T_3MS;
          3'b010: t_wd = `T_10MS;
          3'b100: t_wd = `T_100MS;
          3'b101: t_wd = `T_300MS;
          3'b110: t_wd = `T_3S;
          default: t_wd = `T_60S;
        endcase
        t_delay = `T_60S;
      end
      default: begin
        // Startup delay table; first-edge codes have no fixed period
        case (sel_live_reg)
          3'b000: t_delay = `T_3MS;
          3'b001: t_delay = `T_3S;
          3'b100: t_delay = `T_200US;
          3'b101: t_delay = FIRST_EDGE;
          3'b110: t_delay = FIRST_EDGE;
          default: t_delay = `T_60S;
        endcase
        // Timeout table
        case (sel_live_reg)
          3'b000: t_wd = `T_3MS;
          3'b001: t_wd = `T_3S;
          3'b010: t_wd = `T_1S;
          3'b100: t_wd = `T_30US;
          3'b101: t_wd = `T_1S;
          default: t_wd = `T_10S;
        endcase
      end
    endcase
  end

  // Main sequencer
  always @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= ST_SETTLE;
      count_reg <= 32'h0;
      kick_prev_reg <= 1'b0;
      sel_prev_reg <= 3'h0;
      sel_live_reg <= 3'h0;
      change_pend_reg <= 1'b1;
      fault_pulse_n <= 1'b1;
      fault_oe <= 1'b0;
      disabled_out <= 1'b0;
    end else begin
      kick_prev_reg <= kick_s;
      sel_prev_reg <= sel_s;
      fault_oe <= 1'b0;
      fault_pulse_n <= 1'b1;
      if (sel_changed) begin
        change_pend_reg <= 1'b1;
      end
      case (state_reg)
        ST_SETTLE: begin
          // Kicks ignored; live select follows the pins every settle cycle
          sel_live_reg <= sel_s;
          change_pend_reg <= 1'b0;
          if (sel_changed) begin
            count_reg <= 32'h0;
          end else if (tick) begin
            count_reg <= count_reg + 32'h1;
          end
          if (!sel_changed && tick && count_reg >= `SETTLE_US - 1) begin
            count_reg <= 32'h0;
            state_reg <= (sel_s == `SEL_DISABLED) ? ST_OFF : ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          // No counting of timeouts nor pulses here
          if (sel_changed) begin
            count_reg <= 32'h0;
            state_reg <= ST_SETTLE;
          end else if (t_delay == FIRST_EDGE) begin
            if (kick_edge) begin
              state_reg <= ST_RUN;
            end
          end else if (tick) begin
            count_reg <= count_reg + 32'h1;
            if (count_reg >= t_delay + (t_delay >> 1)) begin
              count_reg <= 32'h0;
              state_reg <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (sel_changed) begin
            count_reg <= 32'h0;
            state_reg <= ST_SETTLE;
          end else if (kick_edge) begin
            count_reg <= 32'h0;
          end else if (tick) begin
            count_reg <= count_reg + 32'h1;
            if (count_reg >= t_wd + (t_wd >> 1)) begin
              count_reg <= 32'h0;
              state_reg <= ST_FAULT;
              fault_pulse_n <= 1'b0;
              fault_oe <= 1'b1;
            end
          end
        end
        ST_FAULT: begin
          // Kicks ignored; pulse runs to completion
          fault_pulse_n <= 1'b0;
          fault_oe <= 1'b1;
          if (tick) begin
            count_reg <= count_reg + 32'h1;
          end
          if (tick && count_reg >= PULSE_US - 1) begin
            count_reg <= 32'h0;
            fault_pulse_n <= 1'b1;
            fault_oe <= 1'b0;
            state_reg <= (change_pend_reg || sel_changed) ? ST_SETTLE : ST_RUN;
          end
        end
        ST_OFF: begin
          count_reg <= 32'h0;
          if (sel_changed) begin
            state_reg <= ST_SETTLE;
          end
        end
        default: begin
          state_reg <= ST_SETTLE;
          count_reg <= 32'h0;
        end
      endcase
      disabled_out <= (state_reg == ST_OFF);
    end
  end

endmodule // pin_selectable_watchdog

`default_nettype wire

/* File: bench/wdog_sva.sv */
// Concurrent checks on the watchdog pins.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module wdog_sva #(parameter TICK_CYCLES = 1, parameter PUSH_PULL = 1) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Processor pins
  input wire logic kick_in,
  input wire logic timing_sel_bit0,
  input wire logic timing_sel_bit1,
  input wire logic timing_sel_bit2,
  // Outputs
  input wire logic fault_pulse_n,
  input wire logic fault_oe,
  input wire logic disabled_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pulse width bounds in ticks for the built output class
  localparam int PW_MIN = PUSH_PULL ? 1000 : 100000;
  localparam int PW_MAX = PUSH_PULL ? 3000 : 300000;
  wire logic [2:0] sel_now = {timing_sel_bit2, timing_sel_bit1, timing_sel_bit0};
  logic kick_q;
  logic [2:0] sel_q;
  logic [31:0] idle_cnt, low_cnt, sel_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Cycles since kick edge, while fault low, since select change
  always_ff @(posedge clk_sys) begin
    kick_q <= kick_in;
    sel_q <= sel_now;
    idle_cnt <= (reset || !fault_pulse_n || kick_in != kick_q) ? 32'h0 : idle_cnt + 32'h1;
    low_cnt <= fault_pulse_n ? 32'h0 : low_cnt + 32'h1;
    sel_cnt <= (reset || sel_q != sel_now) ? 32'h0 : sel_cnt + 32'h1;
  end
  a_oe_tracks_fault: assert property (fault_oe == !fault_pulse_n)
    else $error("fault enable out of step");
  a_reset_idle: assert property (disable iff (1'b0) reset |=> fault_pulse_n && !fault_oe)
    else $error("fault active after reset");
  a_off_is_quiet: assert property (disabled_out |-> fault_pulse_n)
    else $error("fault while disabled");
  a_pulse_min: assert property ($rose(fault_pulse_n) |-> low_cnt >= PW_MIN * TICK_CYCLES)
    else $error("fault pulse too short");
  a_pulse_max: assert property (low_cnt <= PW_MAX * TICK_CYCLES)
    else $error("fault pulse too long");
  a_timeout_min: assert property ($fell(fault_pulse_n) |-> idle_cnt >= 30 * TICK_CYCLES)
    else $error("fault before timeout");
  a_settle_quiet: assert property ($fell(fault_pulse_n) |-> sel_cnt > 300 * TICK_CYCLES)
    else $error("fault inside settle");
  a_fresh_period: assert property ($rose(fault_pulse_n) |=> fault_pulse_n [*8])
    else $error("fault right after pulse");
  // Main scenarios seen
  c_fault: cover property ($fell(fault_pulse_n));
  c_pulse_end: cover property ($rose(fault_pulse_n));
  c_off: cover property ($rose(disabled_out));
endmodule // wdog_sva
`default_nettype wire

/* File: bench/wdog_host_model.sv */
// Processor model toggling the kick pin at a set spacing.
// Assumes the bench sets spacing and enable.
`default_nettype none
module wdog_host_model (
  // Clock
  input wire logic clk_sys,
  // Control from bench
  input wire logic kick_en,
  input wire logic [7:0] gap,
  // Kick pin
  output var logic kick_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h0;
  initial kick_in = 1'b0;
  // Each level held gap+1 cycles, 90 ns or more with the bench's gaps and 10 ns clock
  always @(posedge clk_sys) begin
    cnt <= (cnt >= gap) ? 8'h0 : cnt + 8'h1;
    if (kick_en && cnt >= gap) begin
      kick_in <= ~kick_in;
    end
  end
endmodule // wdog_host_model
`default_nettype wire

/* File: bench/pin_selectable_watchdog_tb.sv */
// Self-checking bench for the watchdog, split-table push-pull build.
// Assumes one tick per clock so every period is in cycles.
`default_nettype none
module pin_selectable_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic kick_en = 1'b0;
  logic [2:0] sel = 3'h4;
  logic [7:0] gap = 8'h10;
  wire logic kick_in, fault_pulse_n, fault_oe, disabled_out;
  int fails = 0;
  int cmp_count = 0;
  int lows = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  // Count cycles with fault low
  always @(posedge clk_sys) if (!reset && fault_pulse_n !== 1'b1) lows++;
  wdog_host_model i_wdog_host_model (.clk_sys, .kick_en, .gap, .kick_in);
  pin_selectable_watchdog #(.VARIANT(2), .PUSH_PULL(1), .TICK_CYCLES(1))
    i_pin_selectable_watchdog (.clk_sys, .reset, .kick_in, .timing_sel_bit0(sel[0]),
    .timing_sel_bit1(sel[1]), .timing_sel_bit2(sel[2]), .fault_pulse_n, .fault_oe,
    .disabled_out);
  task automatic check(input string what, input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Cycles until fault reaches lvl, checked against a span
  task automatic span(input string what, input logic lvl, input int lo, input int hi);
    n = 0;
    while (fault_pulse_n !== lvl && n <= hi) begin
      @(posedge clk_sys);
      n++;
    end
    check(what, n >= lo && n <= hi, 1'b1);
  endtask
  // Minimum timeout of the split-table build, in ticks
  function automatic int wd_min(input logic [2:0] code);
    case (code)
      3'h0: return 3000;
      3'h1: return 3000000;
      3'h2: return 1000000;
      3'h4: return 30;
      3'h5: return 1000000;
      default: return 10000000;
    endcase
  endfunction
  // Minimum startup delay of the split-table build, in ticks; 0 for first edge
  function automatic int dly_min(input logic [2:0] code);
    case (code)
      3'h0: return 3000;
      3'h1: return 3000000;
      3'h4: return 200;
      3'h5: return 0;
      3'h6: return 0;
      default: return 60000000;
    endcase
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #300us;
    fails++;
    wrap_up();
  end
  // Test sequence
  initial begin
    void'($urandom(85262));
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    kick_en <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      gap <= 8'h8 + 8'($urandom_range(0, 16));
      repeat (600) @(posedge clk_sys);
    end
    check("kicked", lows == 0, 1'b1);
    $display("test kicks done");
    kick_en <= 1'b0;
    span("timeout", 1'b0, 20, 3 * wd_min(3'h4) + 5);
    span("width", 1'b1, 1000, 3000);
    span("refresh", 1'b0, wd_min(3'h4), 3 * wd_min(3'h4) + 5);
    sel <= 3'h3;
    repeat (20) @(posedge clk_sys);
    check("pulse kept", fault_pulse_n, 1'b0);
    span("width2", 1'b1, 980, 3000);
    $display("test timeout done");
    repeat (200) @(posedge clk_sys);
    lows = 0;
    repeat (2000) @(posedge clk_sys);
    check("off flag", disabled_out, 1'b1);
    check("off quiet", lows == 0, 1'b1);
    $display("test disable done");
    sel <= 3'h5;
    repeat (3000) @(posedge clk_sys);
    check("first edge wait", lows == 0, 1'b1);
    check("on flag", disabled_out, 1'b0);
    $display("test first edge done");
    sel <= 3'h4;
    span("startup", 1'b0, 300 + dly_min(3'h4), 1000);
    span("width3", 1'b1, 1000, 3000);
    $display("test startup done");
    wrap_up();
  end
endmodule // pin_selectable_watchdog_tb
bind pin_selectable_watchdog wdog_sva #(.TICK_CYCLES(TICK_CYCLES), .PUSH_PULL(PUSH_PULL))
  i_wdog_sva (.clk_sys, .reset, .kick_in, .timing_sel_bit0, .timing_sel_bit1,
  .timing_sel_bit2, .fault_pulse_n, .fault_oe, .disabled_out);
`default_nettype wire
